//--- core/ppo_port.sv
// One eight-pin general purpose port with alternate-function overrides
//==============================================================
`timescale 1ns/1ps
module ppo_port
  import ppo_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic port_write_strobe,
  input wire logic port_read_strobe,
  output logic [7:0] rdata,
  input wire logic sleep_deep,
  input wire logic [7:0] ext_int_enable,
  input wire logic [7:0] pullup_override_enable,
  input wire logic [7:0] pullup_override_value,
  input wire logic [7:0] direction_override_enable,
  input wire logic [7:0] direction_override_value,
  input wire logic [7:0] pin_value_override_enable,
  input wire logic [7:0] pin_value_override_value,
  input wire logic [7:0] latch_toggle_override_enable,
  input wire logic [7:0] input_enable_override_enable,
  input wire logic [7:0] input_enable_override_value,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pad_pullup,
  output logic [7:0] alt_raw_digital_input,
  output logic global_pullup_disable
);

  //==============================================================
  // Storage
  logic [7:0] dir_r; // Direction bits
  logic [7:0] latch_r; // Output latch bits
  logic [7:0] mcu_r; // MCU control register
  logic [7:0] in_meta_r; // First synchroniser stage, raw pad
  logic [7:0] in_sync_r; // Second synchroniser stage
  logic [7:0] in_clamped; // Synchronised level after clamp
  logic [7:0] ien; // Digital input enable per pin
  logic [7:0] oe_nxt; // Driver enable before flop
  logic [7:0] out_nxt; // Driven level before flop
  logic [7:0] pu_nxt; // Pull-up before flop
  logic wr_in; // Write hits input register
  logic wr_dir; // Write hits direction register
  logic wr_out; // Write hits output register
  logic wr_mcu; // Write hits MCU control

  //==============================================================
  // Register decode
  // Strobe qualified by index; used for every register
  function automatic logic ppo_hit(input logic strobe,
    input logic [1:0] idx, input logic [1:0] want);
    return strobe && idx == want;
  endfunction

  // Register write decode, strobe is shared by all pins
  assign wr_in = ppo_hit(port_write_strobe, addr, PPO_ADDR_IN);
  assign wr_dir = ppo_hit(port_write_strobe, addr, PPO_ADDR_DIR);
  assign wr_out = ppo_hit(port_write_strobe, addr, PPO_ADDR_OUT);
  assign wr_mcu = ppo_hit(port_write_strobe, addr, PPO_ADDR_MCU);

  //==============================================================
  // Direction register, whole byte but each bit its own flop
  always_ff @(posedge mclk) begin
    if (reset) begin
      dir_r <= PPO_PORT_RESET;
    end else if (wr_dir) begin
      dir_r <= wdata;
    end
  end

  // Output latch: write, input-register toggle, override toggle
  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_r <= PPO_PORT_RESET;
    end else begin
      // Bits not written keep value; toggle acts per bit
      latch_r <= (wr_out ? wdata : latch_r)
        ^ (wr_in ? wdata : 8'h00)
        ^ latch_toggle_override_enable;
    end
  end

  // MCU control; only writable bits stored, others read zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      mcu_r <= PPO_MCU_RESET;
    end else if (wr_mcu) begin
      mcu_r <= wdata & PPO_MCU_WMASK;
    end
  end

  //==============================================================
  // Input path: two synchroniser stages, then the clamp
  // Pad passes both flops before any gate sees it, so the clamp
  // sits after the synchroniser; the level seen is the same
  // Clamp is shared; interrupt enable lifts it per pin
  always_comb begin
    for (int i = 0; i < PPO_PINS; i++) begin
      if (input_enable_override_enable[i]) begin
        ien[i] = input_enable_override_value[i];
      end else begin
        ien[i] = !sleep_deep || ext_int_enable[i];
      end
    end
  end

  // Two-stage synchroniser on the raw pad level
  always_ff @(posedge mclk) begin
    if (reset) begin
      in_meta_r <= 8'h00;
      in_sync_r <= 8'h00;
    end else begin
      in_meta_r <= pad_in;
      in_sync_r <= in_meta_r;
    end
  end

  // Clamped level goes low; on wake a high pin rises again
  assign in_clamped = in_sync_r & ien;

  // Input for peripherals, one flop since outputs are flopped
  // Receivers still need their own synchroniser
  always_ff @(posedge mclk) begin
    if (reset) begin
      alt_raw_digital_input <= 8'h00;
    end else begin
      alt_raw_digital_input <= in_clamped;
    end
  end

  //==============================================================
  // Output control with overrides
  always_comb begin
    for (int i = 0; i < PPO_PINS; i++) begin
      oe_nxt[i] = direction_override_enable[i] ?
        direction_override_value[i] : dir_r[i];
      out_nxt[i] = pin_value_override_enable[i] ?
        pin_value_override_value[i] : latch_r[i];
      if (pullup_override_enable[i]) begin
        pu_nxt[i] = pullup_override_value[i];
      end else begin
        pu_nxt[i] = {dir_r[i], latch_r[i], mcu_r[PPO_MCU_PU_OFF_BIT]}
          == PPO_PU_PATTERN;
      end
    end
  end

  // Pad drive flops; reset forces tri-state and no pull-up
  // Analog path is a pad net outside this digital logic
  always_ff @(posedge mclk) begin
    if (reset) begin
      pad_oe <= 8'h00;
      pad_pullup <= 8'h00;
      pad_out <= 8'h00;
    end else begin
      pad_oe <= oe_nxt;
      pad_pullup <= pu_nxt;
      pad_out <= out_nxt; // level flopped whether driven or not
    end
  end

  // Global disable shared by all ports
  always_ff @(posedge mclk) begin
    if (reset) begin
      global_pullup_disable <= 1'b0;
    end else begin
      global_pullup_disable <= wr_mcu ?
        wdata[PPO_MCU_PU_OFF_BIT] : mcu_r[PPO_MCU_PU_OFF_BIT];
    end
  end

  //==============================================================
  // Read data, valid only the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (port_read_strobe) begin
      case (addr)
        PPO_ADDR_IN: rdata <= in_clamped;
        PPO_ADDR_DIR: rdata <= dir_r;
        PPO_ADDR_OUT: rdata <= latch_r;
        default: rdata <= mcu_r;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  //==============================================================
  // Checks
  a_reset_tristate: assert property (@(posedge mclk)
    $past(reset) |-> pad_oe == 8'h00 && pad_pullup == 8'h00)
    else $error("pads not released in reset");
  // Global disable wins over the pattern, not over the override
  a_global_pullup_off: assert property (@(posedge mclk)
    disable iff (reset)
    (mcu_r[PPO_MCU_PU_OFF_BIT] && pullup_override_enable == 8'h00)
      |=> pad_pullup == 8'h00)
    else $error("pull-up on with global disable");
  a_dir_override: assert property (@(posedge mclk) disable iff (reset)
    direction_override_enable[0] |=>
      pad_oe[0] == $past(direction_override_value[0]))
    else $error("direction override ignored");
  a_toggle_write: assert property (@(posedge mclk) disable iff (reset)
    (wr_in && !wr_out && latch_toggle_override_enable == 8'h00) |=>
      latch_r == ($past(latch_r) ^ $past(wdata)))
    else $error("input write did not toggle latch");
  // Pad level reaches the second stage two edges later
  a_sync_delay: assert property (@(posedge mclk) disable iff (reset)
    ##2 in_sync_r == $past(pad_in, 2))
    else $error("input sync delay wrong");
  // Clamp seen at the peripheral input one edge later
  a_clamp_low: assert property (@(posedge mclk) disable iff (reset)
    (sleep_deep && ext_int_enable[0] == 1'b0 &&
      !input_enable_override_enable[0]) |=> !alt_raw_digital_input[0])
    else $error("clamp not applied");
  a_value_override: assert property (@(posedge mclk)
    disable iff (reset)
    pin_value_override_enable[1] |=>
      pad_out[1] == $past(pin_value_override_value[1]))
    else $error("value override ignored");

  //==============================================================
  // Further checks on the override, register and read paths
  // Pull-up override value reaches the pad whatever the registers
  a_pullup_override: assert property (@(posedge mclk)
    disable iff (reset)
    pullup_override_enable[2] |=>
      pad_pullup[2] == $past(pullup_override_value[2]))
    else $error("pull-up override ignored");
  // Without pull-up override a pin with its direction bit set never carries the pull-up
  a_output_no_pullup: assert property (@(posedge mclk)
    disable iff (reset)
    (!pullup_override_enable[0] && dir_r[0]) |=> !pad_pullup[0])
    else $error("pull-up on an output pin");
  // Without override the driver follows the direction bit
  a_dir_follow: assert property (@(posedge mclk)
    disable iff (reset)
    !direction_override_enable[3] |=> pad_oe[3] == $past(dir_r[3]))
    else $error("driver enable not from direction bit");
  // Without value override the pad shows the latch
  a_latch_drive: assert property (@(posedge mclk)
    disable iff (reset)
    !pin_value_override_enable[2] |=> pad_out[2] == $past(latch_r[2]))
    else $error("driven level not from latch");
  // Toggle override flips the latch on every edge it is high with no port write
  a_latch_toggle: assert property (@(posedge mclk)
    disable iff (reset)
    (latch_toggle_override_enable[0] && !wr_in && !wr_out) |=>
      latch_r[0] != $past(latch_r[0]))
    else $error("toggle override ignored");
  // Enabled interrupt lifts the clamp for its own pin
  a_clamp_lifted: assert property (@(posedge mclk)
    disable iff (reset)
    (ext_int_enable[6] && !input_enable_override_enable[6]) |=>
      alt_raw_digital_input[6] == $past(in_sync_r[6]))
    else $error("clamp not lifted by interrupt enable");
  // Input enable override with value zero holds the input low in any state
  a_ien_override: assert property (@(posedge mclk)
    disable iff (reset)
    (input_enable_override_enable[0] && !input_enable_override_value[0])
      |=> !alt_raw_digital_input[0])
    else $error("input enable override ignored");
  // Read data stand one cycle only, zero otherwise
  a_read_idle: assert property (@(posedge mclk) disable iff (reset)
    !port_read_strobe |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  // A direction write lands whole, bit for bit
  a_dir_write: assert property (@(posedge mclk)
    disable iff (reset)
    wr_dir |=> dir_r == $past(wdata))
    else $error("direction write lost");
  // Bits that are not writable stay zero
  a_mcu_mask: assert property (@(posedge mclk) disable iff (reset)
    (mcu_r & ~PPO_MCU_WMASK) == 8'h00)
    else $error("reserved control bit set");
  // Shared disable output mirrors the stored control bit
  a_global_copy: assert property (@(posedge mclk)
    disable iff (reset)
    global_pullup_disable == mcu_r[PPO_MCU_PU_OFF_BIT])
    else $error("global pull-up disable out of step");
  a_dir_reset: assert property (@(posedge mclk)
    $past(reset) |-> dir_r == 8'h00 && latch_r == 8'h00)
    else $error("reset did not clear port");
endmodule

//--- core/ppo_pkg.sv
// Constants for the port pin override logic block
package ppo_pkg;
  // Port width
  localparam int PPO_PINS = 8;
  // Register indices on the plain port
  localparam logic [1:0] PPO_ADDR_IN = 2'h0;
  localparam logic [1:0] PPO_ADDR_DIR = 2'h1;
  localparam logic [1:0] PPO_ADDR_OUT = 2'h2;
  localparam logic [1:0] PPO_ADDR_MCU = 2'h3;
  // MCU control layout
  localparam int PPO_MCU_PU_OFF_BIT = 4;
  localparam logic [7:0] PPO_MCU_WMASK = 8'h93;
  localparam logic [7:0] PPO_MCU_RESET = 8'h00;
  localparam logic [7:0] PPO_PORT_RESET = 8'h00;
  // Pull-up enable pattern {dir, latch, disable}
  localparam logic [2:0] PPO_PU_PATTERN = 3'h2;
endpackage

//--- verification/ppo_pad_model.sv
// Pad model: board circuitry on the eight port pins
`timescale 1ns/1ps
module ppo_pad_model (
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_level,
  input wire logic [7:0] ext_drive,
  output logic [7:0] pad_in
);
  //==========================================
  // Resolved pad level
  // Weak board pull-downs, so an idle pad without pull-up reads low, never stale
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_drive[i]) pad_in[i] = ext_level[i];
      else pad_in[i] = pad_pullup[i];
    end
  end
endmodule

//--- verification/port_pin_override_logic_tb_top.sv
// Testbench for the port pin override logic
`timescale 1ns/1ps
module port_pin_override_logic_tb_top;
  import ppo_pkg::*;
  //==========================================
  // Stimulus and observed signals
  logic mclk = 0, reset = 1, ws = 0, rs = 0, slp = 0;
  logic [1:0] addr = 0;
  logic [7:0] wd = 0, eie = 0, pu_en = 0, pu_val = 0, dir_en = 0;
  logic [7:0] dir_val = 0, pv_en = 0, pv_val = 0, tgl_en = 0;
  logic [7:0] dioe = 0, diov = 0;
  logic [7:0] ext_l = 0, ext_d = 0, rdata, pin, pout, poe, ppu, alt;
  logic gpd;
  int bad_count = 0, n_compared = 0;
  ppo_port i_dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wd),
    .port_write_strobe(ws), .port_read_strobe(rs), .rdata(rdata),
    .sleep_deep(slp), .ext_int_enable(eie),
    .pullup_override_enable(pu_en), .pullup_override_value(pu_val),
    .direction_override_enable(dir_en), .direction_override_value(dir_val),
    .pin_value_override_enable(pv_en), .pin_value_override_value(pv_val),
    .latch_toggle_override_enable(tgl_en),
    .input_enable_override_enable(dioe), .input_enable_override_value(diov),
    .pad_in(pin), .pad_out(pout), .pad_oe(poe), .pad_pullup(ppu),
    .alt_raw_digital_input(alt), .global_pullup_disable(gpd));
  ppo_pad_model i_pads (.pad_out(pout), .pad_oe(poe), .pad_pullup(ppu),
    .ext_level(ext_l), .ext_drive(ext_d), .pad_in(pin));
  //==========================================
  // Clock, 5 ns period
  initial forever #2.5 mclk = ~mclk;
  //==========================================
  // Access tasks and comparison
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wd <= d;
    ws <= 1'b1;
    @(posedge mclk);
    ws <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input string n);
    @(posedge mclk);
    addr <= a;
    rs <= 1'b1;
    @(posedge mclk);
    rs <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  // Pads settle two cycles after a cause; margin added
  task automatic settle;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  //==========================================
  // Watchdog, tests need about 80 cycles
  initial begin
    #20000;
    bad_count++;
    final_report;
  end
  //==========================================
  // Test sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    settle;
    chk("pad_oe", 8'h00, poe);
    rd(PPO_ADDR_DIR, PPO_PORT_RESET, "dir");
    rd(PPO_ADDR_OUT, PPO_PORT_RESET, "latch");
    $display("test reset done");
    wr(PPO_ADDR_DIR, 8'h0F);
    wr(PPO_ADDR_OUT, 8'hA5);
    settle;
    chk("pad_oe", 8'h0F, poe);
    chk("pad_out", 8'h05, pout & poe);
    chk("pad_pullup", 8'hA0, ppu);
    wr(PPO_ADDR_IN, 8'h81);
    rd(PPO_ADDR_OUT, 8'h24, "latch");
    wr(PPO_ADDR_MCU, 8'hFF);
    rd(PPO_ADDR_MCU, PPO_MCU_WMASK, "mcu");
    settle;
    chk("pad_pullup", 8'h00, ppu);
    chk("pullup_disable", 8'h01, {7'h00, gpd});
    $display("test gpio done");
    // Global disable stays set: the override must ignore it
    @(posedge mclk);
    pu_en <= 8'hFF;
    pu_val <= 8'h0F;
    dir_en <= 8'hF0;
    dir_val <= 8'h30;
    pv_en <= 8'hFF;
    pv_val <= 8'h5A;
    settle;
    chk("pad_pullup", 8'h0F, ppu);
    chk("pad_oe", 8'h3F, poe);
    chk("pad_out", 8'h1A, pout & poe);
    @(posedge mclk);
    pu_en <= 8'h00;
    dir_en <= 8'h00;
    pv_en <= 8'h00;
    tgl_en <= 8'h01;
    @(posedge mclk);
    tgl_en <= 8'h00;
    rd(PPO_ADDR_OUT, 8'h25, "latch");
    wr(PPO_ADDR_MCU, 8'h00);
    $display("test override done");
    ext_l <= 8'hF0;
    ext_d <= 8'hF0;
    settle;
    rd(PPO_ADDR_IN, 8'hF5, "pin");
    chk("alt_in", 8'hF5, alt);
    @(posedge mclk);
    slp <= 1'b1;
    eie <= 8'h40;
    settle;
    rd(PPO_ADDR_IN, 8'h40, "pin");
    chk("alt_in", 8'h40, alt);
    @(posedge mclk);
    dioe <= 8'h81;
    diov <= 8'h80;
    settle;
    rd(PPO_ADDR_IN, 8'hC0, "pin");
    @(posedge mclk);
    slp <= 1'b0;
    settle;
    rd(PPO_ADDR_IN, 8'hF4, "pin");
    $display("test sleep done");
    // Latch bit 5 input gives a pull-up before reset
    chk("pad_pullup", 8'h20, ppu);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("pad_pullup", 8'h00, ppu);
    chk("pad_oe", 8'h00, poe);
    $display("test second reset done");
    final_report;
  end
endmodule
